// ==== hw/fbx_defines.svh ====
// constants for the fieldbus exchange memory: offsets, codes, reset values, timing
`ifndef FBX_DEFINES_SVH
`define FBX_DEFINES_SVH
// exchange area geometry, byte offsets
`define FBX_MEM_AW 11
`define FBX_DATA_BYTES 11'h600
`define FBX_STAT_HI 11'h600
`define FBX_STAT_LO 11'h601
`define FBX_LIST_FIRST 11'h602
`define FBX_LIST_LAST 11'h611
`define FBX_CTRL_HI 11'h600
`define FBX_CTRL_LO 11'h601
// highest byte a peer may reach in each area
`define FBX_IN_TOP 17'h00611
`define FBX_OUT_TOP 17'h00601
`define FBX_SLAVES 126
// master state codes and reset value of the request word
`define FBX_ST_OFFLINE 2'h0
`define FBX_ST_STOP 2'h1
`define FBX_ST_CLEAR 2'h2
`define FBX_ST_OPERATE 2'h3
`define FBX_CTRL_RESET 2'h1
// modbus function codes
`define FBX_FC_RD_COILS 8'h01
`define FBX_FC_RD_DISC 8'h02
`define FBX_FC_RD_HOLD 8'h03
`define FBX_FC_RD_INREG 8'h04
`define FBX_FC_WR_COIL 8'h05
`define FBX_FC_WR_REG 8'h06
`define FBX_FC_WR_COILS 8'h0F
`define FBX_FC_WR_REGS 8'h10
// command table and poll timing
`define FBX_NCMD 4
`define FBX_IVL_W 21
`define FBX_CLK_PERIOD_NS 5
`define FBX_POLL_UNIT_NS 1000000
`define FBX_POLL_UNIT_CYCLES ((`FBX_POLL_UNIT_NS + `FBX_CLK_PERIOD_NS - 1) / `FBX_CLK_PERIOD_NS)
`endif

// ==== hw/fbx_pkg.sv ====
// types and decode helpers shared by the exchange memory modules
package fbx_pkg;
  `include "fbx_defines.svh"
  // access class of a modbus function code
  typedef enum logic [2:0] {FBX_FC_BAD, FBX_FC_BIT_RD, FBX_FC_BIT_WR, FBX_FC_REG_RD, FBX_FC_REG_WR} fbx_fc_t;
  // command issue mode
  typedef enum logic [1:0] {FBX_EN_DISABLE, FBX_EN_CYCLIC, FBX_EN_CHANGE} fbx_en_t;
  // master-mode issue handshake
  typedef enum logic {FBX_MS_IDLE, FBX_MS_WAIT} fbx_ms_t;
  // one command table entry
  typedef struct packed {
    fbx_en_t en;
    logic [7:0] func;
    logic [10:0] off;
    logic [20:0] ivl;
    logic [20:0] cnt;
    logic pend;
  } fbx_cmd_t;
  // classify a function code into bit or register access
  function automatic fbx_fc_t fbx_classify(input logic [7:0] fc);
    case (fc)
      `FBX_FC_RD_COILS, `FBX_FC_RD_DISC: return FBX_FC_BIT_RD;
      `FBX_FC_WR_COIL, `FBX_FC_WR_COILS: return FBX_FC_BIT_WR;
      `FBX_FC_RD_HOLD, `FBX_FC_RD_INREG: return FBX_FC_REG_RD;
      `FBX_FC_WR_REG, `FBX_FC_WR_REGS: return FBX_FC_REG_WR;
      default: return FBX_FC_BAD;
    endcase
  endfunction
endpackage

// ==== hw/fbx_addr_map.sv ====
// modbus address to exchange byte offset translation
`timescale 1ns/10ps
`default_nettype none
module fbx_addr_map
  import fbx_pkg::*;
(
  input wire logic [15:0] mb_addr,
  input wire logic is_bit,
  output logic [16:0] byte_addr,
  output logic [2:0] bit_sel,
  output logic addr_ok
);
  logic [15:0] a1; // zero-based modbus address
  // translation: bit n of word at N is N*16+n+1, register is N/2+1
  always_comb begin
    a1 = mb_addr - 16'h1;
    addr_ok = (mb_addr != 16'h0);
    bit_sel = a1[2:0];
    if (is_bit) begin
      byte_addr = 17'(a1[15:4]) + 17'(a1[3]);
    end else begin
      byte_addr = {a1, 1'b0};
    end
  end
endmodule
`default_nettype wire

// ==== hw/fbx_cmd_sched.sv ====
// master-mode command table and poll scheduler
`timescale 1ns/10ps
`default_nettype none
module fbx_cmd_sched
  import fbx_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `FBX_POLL_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic ready,
  input wire logic [3:0] dirty,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_idx,
  input wire logic [1:0] cfg_en,
  input wire logic [7:0] cfg_func,
  input wire logic [10:0] cfg_off,
  input wire logic [20:0] cfg_ivl,
  output logic iss_valid,
  output logic [1:0] iss_idx,
  output logic [7:0] iss_func,
  output logic [10:0] iss_off,
  output logic [43:0] off_flat
);
  // scheduler state
  typedef struct packed {
    logic [31:0] ms_cnt;
    fbx_cmd_t [3:0] ent;
    logic iss_valid;
    logic [1:0] iss_idx;
  } fbx_sched_t;
  fbx_sched_t r_reg, r_next;
  logic tick; // one poll unit elapsed
  logic found; // a pending command was picked
  logic [1:0] pick;
  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    r_next = r_reg;
    tick = (r_reg.ms_cnt == 32'(MS_CYCLES - 1));
    found = 1'b0;
    pick = 2'h0;
    r_next.ms_cnt = tick ? 32'h0 : r_reg.ms_cnt + 32'h1;
    r_next.iss_valid = 1'b0;
    for (int i = 0; i < `FBX_NCMD; i++) begin
      // interval count in poll units
      if (tick) begin
        if (r_reg.ent[i].cnt + 21'h1 >= r_reg.ent[i].ivl) begin
          r_next.ent[i].cnt = 21'h0;
          if (r_reg.ent[i].en == FBX_EN_CYCLIC || (r_reg.ent[i].en == FBX_EN_CHANGE && dirty[i])) begin
            r_next.ent[i].pend = 1'b1;
          end
        end else begin
          r_next.ent[i].cnt = r_reg.ent[i].cnt + 21'h1;
        end
      end
    end
    // lowest pending index wins
    for (int i = `FBX_NCMD - 1; i >= 0; i--) begin
      if (r_reg.ent[i].pend && !(cfg_wr && cfg_idx == 2'(i))) begin
        found = 1'b1;
        pick = 2'(i);
      end
    end
    if (run && ready && found) begin
      r_next.iss_valid = 1'b1;
      r_next.iss_idx = pick;
      r_next.ent[pick].pend = 1'b0;
    end
    // configuration rewrite restarts the entry
    if (cfg_wr) begin
      r_next.ent[cfg_idx].en = fbx_en_t'(cfg_en);
      r_next.ent[cfg_idx].func = cfg_func;
      r_next.ent[cfg_idx].off = cfg_off;
      r_next.ent[cfg_idx].ivl = cfg_ivl;
      r_next.ent[cfg_idx].cnt = 21'h0;
      r_next.ent[cfg_idx].pend = 1'b0;
    end
    // halted or disabled entries hold nothing pending
    for (int i = 0; i < `FBX_NCMD; i++) begin
      if (!run || r_next.ent[i].en == FBX_EN_DISABLE) begin
        r_next.ent[i].pend = 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign iss_valid = r_reg.iss_valid;
  assign iss_idx = r_reg.iss_idx;
  assign iss_func = r_reg.ent[r_reg.iss_idx].func;
  assign iss_off = r_reg.ent[r_reg.iss_idx].off;
  assign off_flat = {r_reg.ent[3].off, r_reg.ent[2].off, r_reg.ent[1].off, r_reg.ent[0].off};
  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_disabled_issue;
    @(posedge clk) disable iff (!resetn)
      iss_valid |-> r_reg.ent[iss_idx].en != FBX_EN_DISABLE;
  endproperty
  a_no_disabled_issue: assert property (p_no_disabled_issue) else $error("disabled command issued");
  property p_issue_pulse;
    @(posedge clk) disable iff (!resetn)
      iss_valid |=> !iss_valid;
  endproperty
  a_issue_pulse: assert property (p_issue_pulse) else $error("issue not a single pulse");
endmodule
`default_nettype wire

// ==== hw/fbx_exchange_memory.sv ====
// fieldbus to modbus exchange memory with status, list and control words
`timescale 1ns/10ps
`default_nettype none
module fbx_exchange_memory
  import fbx_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `FBX_POLL_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mb_master_mode,
  input wire logic fb_in_wr,
  input wire logic [10:0] fb_in_addr,
  input wire logic [7:0] fb_in_data,
  input wire logic [10:0] fb_out_addr,
  output logic [7:0] fb_out_data,
  input wire logic [1:0] fb_master_state,
  input wire logic [125:0] fb_slave_live,
  output logic [1:0] fb_state_req,
  input wire logic mb_req_valid,
  input wire logic [7:0] mb_req_func,
  input wire logic [15:0] mb_req_addr,
  input wire logic [15:0] mb_req_wdata,
  output logic mb_rsp_valid,
  output logic mb_rsp_err,
  output logic [15:0] mb_rsp_data,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_idx,
  input wire logic [1:0] cfg_en,
  input wire logic [7:0] cfg_func,
  input wire logic [10:0] cfg_off,
  input wire logic [20:0] cfg_ivl,
  output logic mt_cmd_valid,
  input wire logic mt_cmd_ready,
  output logic [1:0] mt_cmd_idx,
  output logic [7:0] mt_cmd_func,
  output logic [10:0] mt_cmd_off,
  output logic [15:0] mt_cmd_data,
  input wire logic mt_rd_valid,
  input wire logic [1:0] mt_rd_idx,
  input wire logic [15:0] mt_rd_data
);
  ////////////////////////////////////////////////////////////////////////
  // state and storage
  typedef struct packed {
    logic [1:0] ctrl; // requested master state
    logic [1:0] stat; // reported master state
    logic [125:0] live; // slaves in data exchange
    logic [7:0] fb_out_data;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
    fbx_ms_t ms;
    logic cmd_valid;
    logic [1:0] cmd_idx;
    logic [7:0] cmd_func;
    logic [10:0] cmd_off;
    logic [15:0] cmd_data;
    logic [3:0] dirty; // input area changed under a command
  } fbx_core_t;
  fbx_core_t r_reg, r_next;
  logic [7:0] in_mem [0:1535]; // fieldbus to modbus data
  logic [7:0] out_mem [0:1535]; // modbus to fieldbus data
  // slave request decode
  fbx_fc_t cls;
  logic is_bit;
  logic is_rd;
  logic [16:0] byte_a;
  logic [2:0] bit_n;
  logic addr_ok;
  logic in_range;
  logic req_ok; // request accepted without error
  logic [7:0] rd0;
  logic [7:0] rd1;
  // output area write ports
  logic ow_en [2];
  logic [16:0] ow_a [2];
  logic [7:0] ow_d [2];
  // scheduler link
  logic sch_ready;
  logic iss_valid;
  logic [1:0] iss_idx;
  logic [7:0] iss_func;
  logic [10:0] iss_off;
  logic [43:0] off_flat;
  logic [10:0] rd_off; // offset of the answering command
  fbx_fc_t iss_cls;
  ////////////////////////////////////////////////////////////////////////
  // byte readers with status region overlay
  function automatic logic [7:0] in_byte(input logic [16:0] a);
    logic [127:0] pad;
    logic [10:0] li;
    pad = {2'h0, r_reg.live};
    li = a[10:0] - `FBX_LIST_FIRST;
    if (a < 17'(`FBX_DATA_BYTES)) begin
      return in_mem[a[10:0]];
    end else if (a == 17'(`FBX_STAT_LO)) begin
      return {6'h0, r_reg.stat};
    end else if (a >= 17'(`FBX_LIST_FIRST) && a <= 17'(`FBX_LIST_LAST)) begin
      return pad[{li[3:0], 3'h0} +: 8];
    end else begin
      return 8'h00;
    end
  endfunction
  function automatic logic [7:0] out_byte(input logic [16:0] a);
    if (a < 17'(`FBX_DATA_BYTES)) begin
      return out_mem[a[10:0]];
    end else if (a == 17'(`FBX_CTRL_LO)) begin
      return {6'h0, r_reg.ctrl};
    end else begin
      return 8'h00;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // address translation for slave requests
  fbx_addr_map u_map (
    .mb_addr(mb_req_addr),
    .is_bit(is_bit),
    .byte_addr(byte_a),
    .bit_sel(bit_n),
    .addr_ok(addr_ok)
  );
  // command table and poll timer
  fbx_cmd_sched #(
    .MS_CYCLES(MS_CYCLES)
  ) u_sched (
    .clk(clk),
    .resetn(resetn),
    .run(mb_master_mode),
    .ready(sch_ready),
    .dirty(r_reg.dirty),
    .cfg_wr(cfg_wr),
    .cfg_idx(cfg_idx),
    .cfg_en(cfg_en),
    .cfg_func(cfg_func),
    .cfg_off(cfg_off),
    .cfg_ivl(cfg_ivl),
    .iss_valid(iss_valid),
    .iss_idx(iss_idx),
    .iss_func(iss_func),
    .iss_off(iss_off),
    .off_flat(off_flat)
  );
  assign sch_ready = (r_reg.ms == FBX_MS_IDLE) && !iss_valid;
  ////////////////////////////////////////////////////////////////////////
  // slave request decode and read data
  always_comb begin
    cls = fbx_classify(mb_req_func);
    is_bit = (cls == FBX_FC_BIT_RD) || (cls == FBX_FC_BIT_WR);
    is_rd = (cls == FBX_FC_BIT_RD) || (cls == FBX_FC_REG_RD);
    // reads reach the input area, writes the output area
    if (is_bit) begin
      in_range = addr_ok && (byte_a <= (is_rd ? `FBX_IN_TOP : `FBX_OUT_TOP));
    end else begin
      in_range = addr_ok && (17'(byte_a + 17'h1) <= (is_rd ? `FBX_IN_TOP : `FBX_OUT_TOP));
    end
    req_ok = !mb_master_mode && (cls != FBX_FC_BAD) && in_range;
    rd0 = is_rd ? in_byte(byte_a) : out_byte(byte_a);
    rd1 = in_byte(17'(byte_a + 17'h1));
    iss_cls = fbx_classify(iss_func);
    rd_off = off_flat[6'(mt_rd_idx) * 6'hB +: 11];
  end
  ////////////////////////////////////////////////////////////////////////
  // output area write ports: slave writes or master read answers
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      ow_en[k] = 1'b0;
      ow_a[k] = 17'h0;
      ow_d[k] = 8'h00;
    end
    if (mb_req_valid && req_ok && cls == FBX_FC_REG_WR) begin
      // register write: high byte at N, low at N+1
      ow_en[0] = 1'b1;
      ow_a[0] = byte_a;
      ow_d[0] = mb_req_wdata[15:8];
      ow_en[1] = 1'b1;
      ow_a[1] = 17'(byte_a + 17'h1);
      ow_d[1] = mb_req_wdata[7:0];
    end else if (mb_req_valid && req_ok && cls == FBX_FC_BIT_WR) begin
      // single bit read-modify-write
      ow_en[0] = 1'b1;
      ow_a[0] = byte_a;
      ow_d[0] = rd0;
      ow_d[0][bit_n] = (mb_req_wdata != 16'h0);
    end else if (mb_master_mode && mt_rd_valid) begin
      // received remote data lands at the command offset
      ow_en[0] = 1'b1;
      ow_a[0] = {6'h0, rd_off};
      ow_d[0] = mt_rd_data[15:8];
      ow_en[1] = 1'b1;
      ow_a[1] = {6'h0, 11'(rd_off + 11'h1)};
      ow_d[1] = mt_rd_data[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    r_next = r_reg;
    // status snapshot from the fieldbus master
    r_next.stat = fb_master_state;
    r_next.live = fb_slave_live;
    r_next.fb_out_data = out_byte({6'h0, fb_out_addr});
    // control word updates, reserved code keeps the state
    for (int k = 0; k < 2; k++) begin
      if (ow_en[k] && ow_a[k] == 17'(`FBX_CTRL_LO) && ow_d[k][1:0] != `FBX_ST_OFFLINE) begin
        r_next.ctrl = ow_d[k][1:0];
      end
    end
    // slave answer one cycle after the request
    r_next.rsp_valid = mb_req_valid;
    r_next.rsp_err = mb_req_valid && !req_ok;
    r_next.rsp_data = 16'h0;
    if (mb_req_valid && req_ok) begin
      case (cls)
        FBX_FC_BIT_RD: r_next.rsp_data = {15'h0, rd0[bit_n]};
        FBX_FC_REG_RD: r_next.rsp_data = {rd0, rd1};
        default: r_next.rsp_data = mb_req_wdata;
      endcase
    end
    // change tracking per command: issue or reconfig clears, a new write wins
    for (int i = 0; i < `FBX_NCMD; i++) begin
      if (fb_in_wr && fb_in_addr < `FBX_DATA_BYTES &&
          (fb_in_addr == off_flat[i*11 +: 11] || fb_in_addr == 11'(off_flat[i*11 +: 11] + 11'h1))) begin
        r_next.dirty[i] = 1'b1;
      end else if ((iss_valid && iss_idx == 2'(i)) || (cfg_wr && cfg_idx == 2'(i))) begin
        r_next.dirty[i] = 1'b0;
      end
    end
    // master-mode command handshake
    case (r_reg.ms)
      FBX_MS_IDLE: begin
        if (iss_valid) begin
          r_next.ms = FBX_MS_WAIT;
          r_next.cmd_valid = 1'b1;
          r_next.cmd_idx = iss_idx;
          r_next.cmd_func = iss_func;
          r_next.cmd_off = iss_off;
          if (iss_cls == FBX_FC_REG_WR || iss_cls == FBX_FC_BIT_WR) begin
            r_next.cmd_data = {in_byte({6'h0, iss_off}), in_byte({6'h0, 11'(iss_off + 11'h1)})};
          end else begin
            r_next.cmd_data = 16'h0;
          end
        end
      end
      FBX_MS_WAIT: begin
        if (mt_cmd_ready) begin
          r_next.ms = FBX_MS_IDLE;
          r_next.cmd_valid = 1'b0;
        end
      end
      default: begin
        r_next.ms = FBX_MS_IDLE;
        r_next.cmd_valid = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.ctrl <= `FBX_CTRL_RESET;
      r_reg.ms <= FBX_MS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end
  // exchange areas, status bytes never written by the fieldbus
  always_ff @(posedge clk) begin
    if (fb_in_wr && fb_in_addr < `FBX_DATA_BYTES) begin
      in_mem[fb_in_addr] <= fb_in_data;
    end
    for (int k = 0; k < 2; k++) begin
      if (ow_en[k] && ow_a[k] < 17'(`FBX_DATA_BYTES)) begin
        out_mem[ow_a[k][10:0]] <= ow_d[k];
      end
    end
  end
  assign fb_out_data = r_reg.fb_out_data;
  assign fb_state_req = r_reg.ctrl;
  assign mb_rsp_valid = r_reg.rsp_valid;
  assign mb_rsp_err = r_reg.rsp_err;
  assign mb_rsp_data = r_reg.rsp_data;
  assign mt_cmd_valid = r_reg.cmd_valid;
  assign mt_cmd_idx = r_reg.cmd_idx;
  assign mt_cmd_func = r_reg.cmd_func;
  assign mt_cmd_off = r_reg.cmd_off;
  assign mt_cmd_data = r_reg.cmd_data;
  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_slave_answer;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid |=> mb_rsp_valid;
  endproperty
  a_slave_answer: assert property (p_slave_answer) else $error("slave request unanswered");
  property p_master_refuse;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && mb_master_mode |=> mb_rsp_err;
  endproperty
  a_master_refuse: assert property (p_master_refuse) else $error("request served in master mode");
  property p_bad_func;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && fbx_classify(mb_req_func) == FBX_FC_BAD |=> mb_rsp_err && mb_rsp_data == 16'h0;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("bad function accepted");
  property p_bit_width;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && fbx_classify(mb_req_func) == FBX_FC_BIT_RD |=> mb_rsp_data[15:1] == 15'h0;
  endproperty
  a_bit_width: assert property (p_bit_width) else $error("bit read wider than one bit");
  property p_ctrl_set;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && !mb_master_mode && mb_req_func == `FBX_FC_WR_REG && mb_req_addr == 16'h0301 &&
      mb_req_wdata[1:0] != 2'h0 |=> fb_state_req == $past(mb_req_wdata[1:0]);
  endproperty
  a_ctrl_set: assert property (p_ctrl_set) else $error("control word not applied");
  property p_ctrl_rsv;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && !mb_master_mode && mb_req_func == `FBX_FC_WR_REG && mb_req_addr == 16'h0301 &&
      mb_req_wdata[1:0] == 2'h0 |=> $stable(fb_state_req);
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved code changed state");
  property p_status_rd;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && !mb_master_mode && fbx_classify(mb_req_func) == FBX_FC_REG_RD && mb_req_addr == 16'h0301
      |=> mb_rsp_data == {14'h0, $past(r_reg.stat)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status word wrong");
  property p_list_tail;
    @(posedge clk) disable iff (!resetn)
      mb_req_valid && !mb_master_mode && mb_req_func == `FBX_FC_RD_HOLD && mb_req_addr == 16'h0309
      |=> mb_rsp_data[7:0] == {2'h0, $past(r_reg.live[125:120])};
  endproperty
  a_list_tail: assert property (p_list_tail) else $error("last list byte wrong");
  property p_fb_ctrl_rd;
    @(posedge clk) disable iff (!resetn)
      fb_out_addr == `FBX_CTRL_LO |=> fb_out_data == {6'h0, $past(fb_state_req)};
  endproperty
  a_fb_ctrl_rd: assert property (p_fb_ctrl_rd) else $error("control byte not seen by fieldbus");
  property p_cmd_hold;
    @(posedge clk) disable iff (!resetn)
      mt_cmd_valid && !mt_cmd_ready |=> mt_cmd_valid && $stable(mt_cmd_data) && $stable(mt_cmd_idx);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped before accept");
  c_reg_read: cover property (@(posedge clk) disable iff (!resetn)
    mb_req_valid && fbx_classify(mb_req_func) == FBX_FC_REG_RD ##1 !mb_rsp_err);
  c_bit_write: cover property (@(posedge clk) disable iff (!resetn)
    mb_req_valid && fbx_classify(mb_req_func) == FBX_FC_BIT_WR ##1 !mb_rsp_err);
  c_cmd_issue: cover property (@(posedge clk) disable iff (!resetn) mt_cmd_valid ##1 mt_cmd_ready);
endmodule
`default_nettype wire

// ==== sim/fbx_peer_model.sv ====
// far-side model: modbus tcp server answering issued master commands
`timescale 1ns/10ps
`default_nettype none
module fbx_peer_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mt_cmd_valid,
  output logic mt_cmd_ready,
  input wire logic [1:0] mt_cmd_idx,
  input wire logic [7:0] mt_cmd_func,
  output logic mt_rd_valid,
  output logic [1:0] mt_rd_idx,
  output logic [15:0] mt_rd_data,
  output logic [7:0] iss_cnt [4]
);
  logic [1:0] wait_cnt; // stall counter for slow answers
  // accept after 0 or 3 stall cycles, register reads return a fixed word
  always @(posedge clk) begin
    mt_cmd_ready <= 1'b0;
    mt_rd_valid <= 1'b0;
    mt_rd_data <= ~mt_rd_data; // stale data never looks valid
    if (!resetn) begin
      wait_cnt <= 2'h0;
      mt_rd_idx <= 2'h0;
      mt_rd_data <= 16'h0000;
      iss_cnt <= '{4{8'h00}};
    end else if (mt_cmd_valid && !mt_cmd_ready) begin
      if (wait_cnt >= (slow ? 2'h3 : 2'h0)) begin
        mt_cmd_ready <= 1'b1;
        wait_cnt <= 2'h0;
        iss_cnt[mt_cmd_idx] <= iss_cnt[mt_cmd_idx] + 8'h01;
        if (mt_cmd_func == 8'h03 || mt_cmd_func == 8'h04) begin
          mt_rd_valid <= 1'b1;
          mt_rd_idx <= mt_cmd_idx;
          mt_rd_data <= 16'h1234;
        end
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/fieldbus_exchange_memory_tb_top.sv ====
// self-checking bench for the exchange memory
`timescale 1ns/10ps
`default_nettype none
module fieldbus_exchange_memory_tb_top;
  import fbx_pkg::*;
  typedef struct packed {logic [7:0] f; logic [15:0] a, w; logic e; logic [15:0] d; logic [1:0] s;} fbx_row_t;
  logic clk = 0, resetn = 0, mode = 0, slow = 0, fwr = 0, rv = 0, cw = 0;
  logic [10:0] fia = 0, foa = 0, co = 0;
  logic [7:0] fid = 0, fod, rf = 0, cf = 0, ifn;
  logic [1:0] fms = 2'h3, req, ci = 0, ce = 0, ix, rix;
  logic [125:0] live = {6'h21, 120'h101};
  logic [15:0] ra = 0, rw = 0, rd, idat, rdat;
  logic rsv, rse, iv, ir, rdv;
  logic [10:0] iof;
  logic [7:0] cnt [4];
  fbx_row_t rows [11];
  int n_errors = 0, cmp_count = 0;
  fbx_exchange_memory #(.MS_CYCLES(8)) fbx_exchange_memory_i (.clk(clk), .resetn(resetn),
    .mb_master_mode(mode), .fb_in_wr(fwr), .fb_in_addr(fia), .fb_in_data(fid), .fb_out_addr(foa),
    .fb_out_data(fod), .fb_master_state(fms), .fb_slave_live(live), .fb_state_req(req),
    .mb_req_valid(rv), .mb_req_func(rf), .mb_req_addr(ra), .mb_req_wdata(rw), .mb_rsp_valid(rsv),
    .mb_rsp_err(rse), .mb_rsp_data(rd), .cfg_wr(cw), .cfg_idx(ci), .cfg_en(ce), .cfg_func(cf),
    .cfg_off(co), .cfg_ivl(21'h000001), .mt_cmd_valid(iv), .mt_cmd_ready(ir), .mt_cmd_idx(ix),
    .mt_cmd_func(ifn), .mt_cmd_off(iof), .mt_cmd_data(idat), .mt_rd_valid(rdv), .mt_rd_idx(rix),
    .mt_rd_data(rdat));
  fbx_peer_model fbx_peer_model_i (.clk(clk), .resetn(resetn), .slow(slow), .mt_cmd_valid(iv),
    .mt_cmd_ready(ir), .mt_cmd_idx(ix), .mt_cmd_func(ifn), .mt_rd_valid(rdv), .mt_rd_idx(rix),
    .mt_rd_data(rdat), .iss_cnt(cnt));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one fieldbus input byte
  task fbw(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk) {fwr, fia, fid} = {1'b1, a, d};
    @(negedge clk) fwr = 1'b0;
  endtask
  // one slave request, response checked half a cycle after it is taken
  task mbr(input fbx_row_t r);
    @(negedge clk) {rv, rf, ra, rw} = {1'b1, r.f, r.a, r.w};
    @(negedge clk) rv = 1'b0;
    chk("rsp_valid", 16'h0001, {15'h0, rsv});
    chk("rsp_err", {15'h0, r.e}, {15'h0, rse});
    chk("rsp_data", r.d, rd);
    chk("state_req", {14'h0, r.s}, {14'h0, req});
  endtask
  // output area byte as seen by the fieldbus side
  task fbr(input logic [10:0] a, input logic [7:0] e);
    @(negedge clk) foa = a;
    @(negedge clk) chk("fb_out", {8'h00, e}, {8'h00, fod});
  endtask
  task cfg(input logic [1:0] i, input logic [1:0] e, input logic [7:0] f, input logic [10:0] o);
    @(negedge clk) {cw, ci, ce, cf, co} = {1'b1, i, e, f, o};
    @(negedge clk) cw = 1'b0;
  endtask
  // watchdog: whole run needs far fewer cycles
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial begin
    rows[0] = '{8'h03, 16'h0005, 16'h0, 1'b0, 16'hA53C, 2'h1};
    rows[1] = '{8'h01, 16'h0013, 16'h0, 1'b0, 16'h0001, 2'h1};
    rows[2] = '{8'h04, 16'h0301, 16'h0, 1'b0, 16'h0003, 2'h1};
    rows[3] = '{8'h03, 16'h0302, 16'h0, 1'b0, 16'h0101, 2'h1};
    rows[4] = '{8'h07, 16'h0005, 16'h0, 1'b1, 16'h0000, 2'h1};
    rows[5] = '{8'h03, 16'h0000, 16'h0, 1'b1, 16'h0000, 2'h1};
    rows[6] = '{8'h03, 16'h030A, 16'h0, 1'b1, 16'h0000, 2'h1};
    rows[7] = '{8'h06, 16'h0301, 16'h2, 1'b0, 16'h0002, 2'h2};
    rows[8] = '{8'h06, 16'h0301, 16'h0, 1'b0, 16'h0000, 2'h2};
    rows[9] = '{8'h06, 16'h0003, 16'hBEEF, 1'b0, 16'hBEEF, 2'h2};
    rows[10] = '{8'h03, 16'h0309, 16'h0, 1'b0, 16'h0021, 2'h2};
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    chk("reset_req", 16'h0001, {14'h0, req});
    fbw(11'h008, 8'hA5);
    fbw(11'h009, 8'h3C);
    fbw(11'h001, 8'h04);
    repeat (2) @(negedge clk);
    foreach (rows[k]) mbr(rows[k]);
    $display("slave table done");
    fbr(11'h004, 8'hBE);
    fbr(11'h005, 8'hEF);
    fbr(11'h601, 8'h02);
    fbr(11'h600, 8'h00);
    $display("fieldbus reads done");
    // master mode, stalling peer, non-overlapping offsets
    mode = 1'b1;
    slow = 1'b1;
    mbr('{8'h03, 16'h0005, 16'h0, 1'b1, 16'h0000, 2'h2});
    cfg(2'h0, 2'h1, 8'h06, 11'h008);
    cfg(2'h1, 2'h1, 8'h03, 11'h002);
    cfg(2'h2, 2'h0, 8'h06, 11'h00C);
    repeat (300) begin
      @(negedge clk);
      if (iv && ix === 2'h0) begin
        chk("cmd_data", 16'hA53C, idat);
        chk("cmd_off", 16'h0008, {5'h0, iof});
        chk("cmd_func", 16'h0006, {8'h00, ifn});
      end
    end
    chk("cyclic_issued", 16'h0001, {15'h0, cnt[0] > 8'h01});
    chk("disabled_count", 16'h0000, {8'h00, cnt[2]});
    fbr(11'h002, 8'h12);
    fbr(11'h003, 8'h34);
    $display("master mode done");
    // data-change entry alone, quick peer: silent until its bytes change
    slow = 1'b0;
    cfg(2'h0, 2'h0, 8'h06, 11'h008);
    cfg(2'h1, 2'h0, 8'h03, 11'h002);
    cfg(2'h3, 2'h2, 8'h06, 11'h00C);
    repeat (40) @(negedge clk);
    chk("change_idle", 16'h0000, {8'h00, cnt[3]});
    fbw(11'h00D, 8'h77);
    repeat (40) @(negedge clk);
    chk("change_sent", 16'h0001, {8'h00, cnt[3]});
    $display("data change done");
    // reset in mid-run: request word back to stop, table cleared
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk("rerun_req", 16'h0001, {14'h0, req});
    repeat (40) @(negedge clk);
    chk("rerun_idle", 16'h0000, {cnt[0], cnt[1]});
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
